/* File: verilog/l2cb_regs.svh */
// Constants of the level-2 cache bridge configuration block.
// Assumes inclusion by bare name from the package file; the design module only uses its macros.
`ifndef L2CB_REGS_SVH
`define L2CB_REGS_SVH

// ****************************************
// Geometry
// ****************************************
`define L2CB_WAYS 4
`define L2CB_WAY_BYTES 65536
`define L2CB_LINE_BYTES 32
`define L2CB_HALF_BYTES 16
`define L2CB_ATTR_ENTRIES 16
`define L2CB_ATTR_BITS 14

// ****************************************
// Address windows
// ****************************************
`define L2CB_CACHABLE_LAST 32'h7FFF_FFFF
`define L2CB_CFG_BASE 32'hF000_0000
`define L2CB_CFG_LAST 32'hF0FF_FFFF
`define L2CB_IO_BASE 32'hFFE0_0000
`define L2CB_IO_LAST 32'hFFEF_FFFF

// ****************************************
// Tag entry field positions
// ****************************************
`define L2CB_TAG_MSB 31
`define L2CB_TAG_LSB 16
`define L2CB_HALF_SEL_BIT 4

// ****************************************
// Reset values
// ****************************************
`define L2CB_ERR_TYPE_NONE 2'h0
`endif

/* File: verilog/l2cb_pkg.sv */
// Types of the level-2 cache bridge configuration block.
// Assumes the constants header is on the include path.
`include "l2cb_regs.svh"
package l2cb_pkg;
    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [1:0] {
        L2CB_REPL_LRU, L2CB_REPL_RANDOM, L2CB_REPL_IDX_FIXED, L2CB_REPL_IDX_MOD
    } l2cb_repl_t;
    typedef enum logic [1:0] {
        L2CB_WIN_NONE, L2CB_WIN_MEM, L2CB_WIN_CFG, L2CB_WIN_IO
    } l2cb_win_t;
    typedef enum logic [1:0] {
        L2CB_ERR_CORR, L2CB_ERR_UNCORR, L2CB_ERR_WPROT, L2CB_ERR_BACKEND
    } l2cb_err_t;

    // ****************************************
    // Structures
    // ****************************************
    typedef struct packed {
        logic enable;
        l2cb_repl_t policy;
        logic write_through;
        logic hprot_en;
        logic read_hit_bypass;
        logic [1:0] replace_target;
        logic err_resp_en;
    } l2cb_ctrl_t;

    // Access field: 00 uncached, 01 write-through, else no effect
    // Protect field: bit 0 write-protect, bit 1 entry enabled
    typedef struct packed {
        logic [13:0] addr;
        logic [13:0] mask;
        logic [1:0] access;
        logic [1:0] protect;
    } l2cb_attr_t;

    typedef struct packed {
        l2cb_win_t win;
        logic cachable;
        logic bufferable;
        logic write_through;
        logic from_cache;
        logic to_memory;
        logic allocate;
        logic wprot_block;
        logic err_resp;
    } l2cb_dec_t;

    typedef struct packed {
        logic valid;
        l2cb_err_t kind;
        logic [31:0] addr;
    } l2cb_errstat_t;
endpackage : l2cb_pkg

/* File: verilog/l2cb_config.sv */
// Configuration, access classification, victim choice and error status
// of the level-2 cache bridge. Assumes the storage and bus engines
// around it present one access per cycle from the same clock domain.
`timescale 1ns/1ns

// Summary of operation
// RULE1: Cache enable is low after reset until software sets it.
// RULE2: Four ways of 64 KiB each, 32-byte lines.
// RULE3: Victim policy LRU, pseudo-random or requester index; LRU after reset.
// RULE4: Requester n below way count evicts the nth way.
// RULE5: Out-of-range requesters may evict the fixed replace-target way.
// RULE6: Or out-of-range requesters evict requester index modulo ways.
// RULE7: Software disables and flushes before switching to write-through.
// RULE8: Attribute entry: 14-bit address, 14-bit mask, two 2-bit controls.
// RULE9: Entry hits on masked top 14 address bits; else control register rules.
// RULE10: Sixteen attribute entries checked against every access.
// RULE11: Software disables and flushes before changing attribute entries.
// RULE12: Write protection applies even with the cache disabled.
// RULE13: Addresses 0x00000000 to 0x7FFFFFFF are cachable by default.
// RULE14: HPROT only demotes; bit 3 cacheable, bit 2 bufferable.
// RULE15: Non-cachable: hits from cache, misses to memory, write hits per buffering.
// RULE16: Bypass bit sends non-cachable non-bufferable read hits to memory.
// RULE17: Tag entry: tag 31:16, zeros 15:10, valid 9:8, dirty 7:6, LRU 4:0.
// RULE18: Valid and dirty tracked per 16-byte half line.
// RULE19: Decode memory, configuration and backend IO windows.
// RULE20: Record error type and address; uncorrectable overwrites, others wait.
// RULE21: Four pending error bits, interrupt when pending and unmasked.
// RULE22: Uncorrectable read data error answers ERROR; optionally stored-error match.
module l2cb_config
    import l2cb_pkg::*;
#(
    parameter int WAYS = `L2CB_WAYS,
    parameter int ENTRIES = `L2CB_ATTR_ENTRIES
) (
    // Clock, reset, enable
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    // Control
    input wire logic I_CTRL_WE,
    input wire l2cb_ctrl_t I_CTRL,
    input wire logic I_FLUSH_DISABLE,
    // Attribute entry write port
    input wire logic I_ATTR_WE,
    input wire logic [3:0] I_ATTR_IDX,
    input wire l2cb_attr_t I_ATTR,
    // Access lookup
    input wire logic I_ACC_VALID,
    input wire logic [31:0] I_ACC_ADDR,
    input wire logic [3:0] I_ACC_HPROT,
    input wire logic I_ACC_WRITE,
    input wire logic I_ACC_HIT,
    input wire logic [3:0] I_ACC_MASTER,
    input wire logic [1:0] I_LRU_WAY,
    // Tag entry assembly
    input wire logic [1:0] I_TAG_VALID,
    input wire logic [1:0] I_TAG_DIRTY,
    input wire logic [4:0] I_TAG_LRU,
    // Error events and status control
    input wire logic I_ERR_CORR,
    input wire logic I_ERR_UNCORR_RD,
    input wire logic I_ERR_BACKEND,
    input wire logic [31:0] I_ERR_ADDR,
    input wire logic I_ERR_CLEAR,
    input wire logic [3:0] I_PEND_CLEAR,
    input wire logic [3:0] I_IRQ_MASK,
    // Control and decode results
    output l2cb_ctrl_t O_CTRL,
    output logic O_DEC_VALID,
    output l2cb_dec_t O_DEC,
    output logic [1:0] O_VICTIM,
    output logic O_HALF_SEL,
    output logic [31:0] O_TAG_ENTRY,
    // Error reporting
    output l2cb_errstat_t O_ERR_STATUS,
    output logic [3:0] O_PENDING,
    output logic O_IRQ
);
    // ****************************************
    // Functions
    // ****************************************
    // Window of a front-side address
    function automatic l2cb_win_t win_of(input logic [31:0] a);
        if (a <= `L2CB_CACHABLE_LAST) begin
            win_of = L2CB_WIN_MEM; // see RULE19
        end else if (a >= `L2CB_CFG_BASE && a <= `L2CB_CFG_LAST) begin
            win_of = L2CB_WIN_CFG; // see RULE19
        end else if (a >= `L2CB_IO_BASE && a <= `L2CB_IO_LAST) begin
            win_of = L2CB_WIN_IO; // see RULE19
        end else begin
            win_of = L2CB_WIN_NONE;
        end
    endfunction : win_of

    // Masked compare of the top address bits against one entry
    function automatic logic attr_hit(input l2cb_attr_t e, input logic [13:0] top);
        attr_hit = e.protect[1] && ((top & e.mask) == (e.addr & e.mask)); // see RULE9
    endfunction : attr_hit

    // Tag word with zero and reserved fields forced
    function automatic logic [31:0] tag_pack(input logic [15:0] t, input logic [1:0] v,
                                             input logic [1:0] d, input logic [4:0] l);
        tag_pack = {t, 6'h00, v, d, 1'b0, l}; // see RULE17
    endfunction : tag_pack

    // ****************************************
    // State
    // ****************************************
    l2cb_ctrl_t ctrl, next_ctrl;
    l2cb_attr_t attr [ENTRIES];
    l2cb_attr_t next_attr [ENTRIES];
    logic [7:0] lfsr, next_lfsr;
    logic dec_valid, next_dec_valid;
    l2cb_dec_t dec, next_dec;
    logic [1:0] victim, next_victim;
    logic half_sel, next_half_sel;
    logic [31:0] tag_entry, next_tag_entry;
    l2cb_errstat_t err, next_err;
    logic [3:0] pending, next_pending;
    logic irq, next_irq;

    // ****************************************
    // Control and attribute entries
    // ****************************************
    // Flush-with-disable clears the enable, so software need not race it
    always_comb begin
        next_ctrl = ctrl;
        for (int i = 0; i < ENTRIES; i++) begin
            next_attr[i] = attr[i];
        end
        if (I_CTRL_WE) begin
            next_ctrl = I_CTRL;
        end
        if (I_FLUSH_DISABLE) begin
            next_ctrl.enable = 1'b0;
        end
        // Changes take effect at once; software is expected to flush first
        if (I_ATTR_WE) begin
            next_attr[I_ATTR_IDX] = I_ATTR; // see RULE8, see RULE11
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ctrl <= '0; // see RULE1, see RULE3
            for (int i = 0; i < ENTRIES; i++) begin
                attr[i] <= '0;
            end
        end else if (I_CE) begin
            ctrl <= next_ctrl;
            for (int i = 0; i < ENTRIES; i++) begin
                attr[i] <= next_attr[i];
            end
        end
    end

    // ****************************************
    // Access classification
    // ****************************************
    // Lowest matching entry wins when several overlap
    always_comb begin
        logic hit_any;
        logic wp;
        logic uncached;
        logic wt;
        logic cach;
        logic buff;
        logic [13:0] top;
        hit_any = 1'b0;
        wp = 1'b0;
        uncached = 1'b0;
        wt = 1'b0;
        cach = 1'b0;
        buff = 1'b0;
        top = I_ACC_ADDR[31:18];
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (attr_hit(attr[i], top)) begin // see RULE10
                hit_any = 1'b1;
                wp = attr[i].protect[0];
                uncached = (attr[i].access == 2'h0);
                wt = (attr[i].access == 2'h1);
            end
        end
        next_dec = '0;
        next_dec.win = win_of(I_ACC_ADDR);
        cach = ctrl.enable && (next_dec.win == L2CB_WIN_MEM); // see RULE1, see RULE13
        cach = cach && !(hit_any && uncached); // see RULE9
        cach = cach && !(ctrl.hprot_en && !I_ACC_HPROT[3]); // see RULE14
        buff = ctrl.hprot_en ? I_ACC_HPROT[2] : 1'b1; // see RULE14
        next_dec.cachable = cach;
        next_dec.bufferable = buff;
        next_dec.write_through = ctrl.write_through || (hit_any && wt); // see RULE9
        // Protection is checked ahead of the enable on purpose
        next_dec.wprot_block = I_ACC_WRITE && hit_any && wp; // see RULE12
        if (!ctrl.enable || next_dec.win != L2CB_WIN_MEM) begin
            next_dec.to_memory = 1'b1;
        end else if (!I_ACC_WRITE) begin
            if (I_ACC_HIT) begin
                next_dec.from_cache = !(!cach && !buff && ctrl.read_hit_bypass); // see RULE16
                next_dec.to_memory = !next_dec.from_cache;
            end else begin
                next_dec.allocate = cach; // see RULE15
                next_dec.to_memory = 1'b1;
            end
        end else begin
            if (I_ACC_HIT) begin
                next_dec.from_cache = 1'b1;
                next_dec.to_memory = cach ? next_dec.write_through : !buff; // see RULE15
            end else begin
                next_dec.allocate = cach;
                next_dec.to_memory = !cach || next_dec.write_through; // see RULE15
            end
        end
        if (next_dec.wprot_block) begin
            next_dec.from_cache = 1'b0;
            next_dec.to_memory = 1'b0;
            next_dec.allocate = 1'b0;
        end
        // A read faulting uncorrectably, or touching the stored error address
        next_dec.err_resp = (!I_ACC_WRITE && I_ERR_UNCORR_RD) // see RULE22
            || (ctrl.err_resp_en && err.valid && err.addr == I_ACC_ADDR); // see RULE22
        next_dec_valid = I_ACC_VALID;
        next_half_sel = I_ACC_ADDR[`L2CB_HALF_SEL_BIT]; // see RULE18
        next_tag_entry = tag_pack(I_ACC_ADDR[`L2CB_TAG_MSB:`L2CB_TAG_LSB],
                                  I_TAG_VALID, I_TAG_DIRTY, I_TAG_LRU); // see RULE2
    end

    // ****************************************
    // Victim way selection
    // ****************************************
    // Random source is an 8-bit LFSR stepped each enabled cycle
    always_comb begin
        next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        unique case (ctrl.policy)
            L2CB_REPL_LRU: begin
                next_victim = I_LRU_WAY; // see RULE3
            end
            L2CB_REPL_RANDOM: begin
                next_victim = lfsr[1:0]; // see RULE3
            end
            L2CB_REPL_IDX_FIXED: begin
                if (int'(I_ACC_MASTER) < WAYS) begin
                    next_victim = I_ACC_MASTER[1:0]; // see RULE4
                end else begin
                    next_victim = ctrl.replace_target; // see RULE5
                end
            end
            L2CB_REPL_IDX_MOD: begin
                next_victim = I_ACC_MASTER[1:0]; // see RULE4, see RULE6
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            lfsr <= 8'h01;
            victim <= 2'h0;
            dec_valid <= 1'b0;
            dec <= '0;
            half_sel <= 1'b0;
            tag_entry <= 32'h0000_0000;
        end else if (I_CE) begin
            lfsr <= next_lfsr;
            victim <= next_victim;
            dec_valid <= next_dec_valid;
            dec <= next_dec;
            half_sel <= next_half_sel;
            tag_entry <= next_tag_entry;
        end
    end

    // ****************************************
    // Error status and pending bits
    // ****************************************
    // A new event in the clearing cycle is kept: set beats clear
    always_comb begin
        logic [3:0] ev;
        logic wp_ev;
        wp_ev = dec_valid && dec.wprot_block;
        ev = {I_ERR_BACKEND, wp_ev, I_ERR_UNCORR_RD, I_ERR_CORR};
        next_err = err;
        if (I_ERR_CLEAR) begin
            next_err.valid = 1'b0;
        end
        if (I_ERR_UNCORR_RD) begin
            next_err = '{1'b1, L2CB_ERR_UNCORR, I_ERR_ADDR}; // see RULE20
        end else if (!err.valid || I_ERR_CLEAR) begin
            if (wp_ev) begin
                next_err = '{1'b1, L2CB_ERR_WPROT, I_ERR_ADDR}; // see RULE20
            end else if (I_ERR_BACKEND) begin
                next_err = '{1'b1, L2CB_ERR_BACKEND, I_ERR_ADDR}; // see RULE20
            end else if (I_ERR_CORR) begin
                next_err = '{1'b1, L2CB_ERR_CORR, I_ERR_ADDR}; // see RULE20
            end
        end
        next_pending = (pending & ~I_PEND_CLEAR) | ev; // see RULE21
        next_irq = |(next_pending & ~I_IRQ_MASK); // see RULE21
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            err <= '0;
            pending <= 4'h0;
            irq <= 1'b0;
        end else if (I_CE) begin
            err <= next_err;
            pending <= next_pending;
            irq <= next_irq;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign O_CTRL = ctrl;
    assign O_DEC_VALID = dec_valid;
    assign O_DEC = dec;
    assign O_VICTIM = victim;
    assign O_HALF_SEL = half_sel;
    assign O_TAG_ENTRY = tag_entry;
    assign O_ERR_STATUS = err;
    assign O_PENDING = pending;
    assign O_IRQ = irq;
endmodule : l2cb_config

/* File: tb/l2cb_store_model.sv */
// Storage-side stand-in answering tag lookups for the config block.
// Assumes the bench drives the access address; answers in the same cycle.
`timescale 1ns/1ns
module l2cb_store_model (
    // Lookup request
    input wire logic [31:0] i_addr,
    // Lookup answer
    output logic o_hit,
    output logic [1:0] o_lru_way,
    output logic [1:0] o_valid,
    output logic [1:0] o_dirty,
    output logic [4:0] o_lru
);
    // Answers come from address bits, so every case is repeatable
    always_comb begin
        o_hit = i_addr[6];
        o_lru_way = i_addr[9:8];
        o_valid = i_addr[11:10]; // One bit per half line
        o_dirty = i_addr[13:12];
        o_lru = i_addr[20:16];
    end
endmodule : l2cb_store_model

/* File: tb/l2cb_properties.sv */
// Timing checks on the ports of the cache bridge config block.
// Assumes one clock and a synchronous reset held with the enable high.
`timescale 1ns/1ns
module l2cb_properties
    import l2cb_pkg::*;
(
    // Clock, reset and controls
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_CE,
    input wire logic I_CTRL_WE,
    input wire l2cb_ctrl_t I_CTRL,
    input wire logic I_FLUSH_DISABLE,
    // Access and error inputs
    input wire logic I_ACC_VALID,
    input wire logic [31:0] I_ACC_ADDR,
    input wire logic I_ACC_WRITE,
    input wire logic [1:0] I_TAG_VALID,
    input wire logic [1:0] I_TAG_DIRTY,
    input wire logic [4:0] I_TAG_LRU,
    input wire logic I_ERR_UNCORR_RD,
    input wire logic [31:0] I_ERR_ADDR,
    input wire logic [3:0] I_IRQ_MASK,
    // Outputs watched
    input wire l2cb_ctrl_t O_CTRL,
    input wire l2cb_dec_t O_DEC,
    input wire logic O_HALF_SEL,
    input wire logic [31:0] O_TAG_ENTRY,
    input wire l2cb_errstat_t O_ERR_STATUS,
    input wire logic [3:0] O_PENDING,
    input wire logic O_IRQ
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // Reset leaves the cache off with LRU and nothing pending
    chk_reset_clears: assert property ($fell(I_RESET) |-> O_CTRL == '0 && O_PENDING == 4'h0)
        else $error("control or pending not clear after reset");
    chk_ctrl_load: assert property (I_CE && I_CTRL_WE && !I_FLUSH_DISABLE |=> O_CTRL == $past(I_CTRL))
        else $error("control write not taken");
    chk_tag_layout: assert property (I_CE |=> O_TAG_ENTRY == {$past(I_ACC_ADDR[31:16]), 6'h00,
        $past(I_TAG_VALID), $past(I_TAG_DIRTY), 1'h0, $past(I_TAG_LRU)})
        else $error("tag entry fields misplaced");
    chk_half_sel: assert property (I_CE |=> O_HALF_SEL == $past(I_ACC_ADDR[4]))
        else $error("half line select wrong");
    chk_cfg_window: assert property (I_CE && I_ACC_VALID && I_ACC_ADDR[31:24] == 8'hF0
        |=> O_DEC.win == L2CB_WIN_CFG)
        else $error("config window not decoded");
    chk_off_to_mem: assert property (I_CE && I_ACC_VALID && !I_ACC_WRITE && !O_CTRL.enable
        |=> O_DEC.to_memory && !O_DEC.cachable && !O_DEC.from_cache)
        else $error("disabled read not sent to memory");
    chk_irq_mask: assert property (I_CE |=> O_IRQ == |(O_PENDING & ~$past(I_IRQ_MASK)))
        else $error("interrupt disagrees with pending and mask");
    chk_uncorr_store: assert property (I_CE && I_ERR_UNCORR_RD
        |=> O_ERR_STATUS == {1'h1, L2CB_ERR_UNCORR, $past(I_ERR_ADDR)})
        else $error("uncorrectable error not stored");
endmodule : l2cb_properties
bind l2cb_config l2cb_properties i_chk (.*);

/* File: tb/tb_top.sv */
// Self-checking bench for the cache bridge configuration block.
// Assumes the storage stand-in answers lookups from the access address.
`timescale 1ns/1ns
module tb_top;
    import l2cb_pkg::*;
    // ****************************************
    // Signals and tasks
    // ****************************************
    logic I_CLK, I_RESET, I_CE, I_CTRL_WE, I_FLUSH_DISABLE, I_ATTR_WE, I_ACC_VALID;
    logic I_ACC_WRITE, I_ACC_HIT, I_ERR_CORR, I_ERR_UNCORR_RD, I_ERR_BACKEND, I_ERR_CLEAR;
    logic [3:0] I_ATTR_IDX, I_ACC_HPROT, I_ACC_MASTER, I_PEND_CLEAR, I_IRQ_MASK, O_PENDING;
    logic [31:0] I_ACC_ADDR, I_ERR_ADDR, O_TAG_ENTRY;
    logic [1:0] I_LRU_WAY, I_TAG_VALID, I_TAG_DIRTY, O_VICTIM;
    logic [4:0] I_TAG_LRU;
    logic O_DEC_VALID, O_HALF_SEL, O_IRQ;
    l2cb_ctrl_t I_CTRL, O_CTRL;
    l2cb_attr_t I_ATTR;
    l2cb_dec_t O_DEC;
    l2cb_errstat_t O_ERR_STATUS;
    int error_cnt = 0;
    int checked = 0;
    logic [31:0] wa [7] = '{32'h7FFF_FFE0, 32'h8000_0000, 32'hF000_0000, 32'hF0FF_FFFC,
        32'hF100_0000, 32'hFFE0_0000, 32'hFFDF_FFFC};
    l2cb_win_t ww [7] = '{L2CB_WIN_MEM, L2CB_WIN_NONE, L2CB_WIN_CFG, L2CB_WIN_CFG,
        L2CB_WIN_NONE, L2CB_WIN_IO, L2CB_WIN_NONE};
    // Clock at 100 MHz
    initial begin
        I_CLK = 1'h0;
        forever #5 I_CLK = ~I_CLK;
    end
    l2cb_config i_dut (.*);
    l2cb_store_model i_store (.i_addr(I_ACC_ADDR), .o_hit(I_ACC_HIT), .o_lru_way(I_LRU_WAY),
        .o_valid(I_TAG_VALID), .o_dirty(I_TAG_DIRTY), .o_lru(I_TAG_LRU));
    task chk(input string n, input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task end_sim();
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    // One access cycle; outputs are looked at just after the answer edge
    task acc(input logic [31:0] a, input logic [3:0] hp, input logic w, input logic [3:0] m);
        @(posedge I_CLK);
        I_ACC_VALID <= 1'h1;
        I_ACC_ADDR <= a;
        I_ACC_HPROT <= hp;
        I_ACC_WRITE <= w;
        I_ACC_MASTER <= m;
        @(posedge I_CLK);
        I_ACC_VALID <= 1'h0;
        #1;
    endtask : acc
    // Flags packed as cachable, from cache, to memory, allocate, blocked
    task dc(input logic [31:0] a, input logic [3:0] hp, input logic w, input logic [4:0] e);
        acc(a, hp, w, 4'h0);
        chk("decode", {O_DEC.cachable, O_DEC.from_cache, O_DEC.to_memory, O_DEC.allocate,
            O_DEC.wprot_block}, e);
    endtask : dc
    task setc(input logic en, input l2cb_repl_t p, input logic hp, input logic by,
        input logic [1:0] t);
        @(posedge I_CLK);
        I_CTRL <= '{en, p, 1'h0, hp, by, t, 1'h1};
        I_CTRL_WE <= 1'h1;
        @(posedge I_CLK);
        I_CTRL_WE <= 1'h0;
    endtask : setc
    task attr(input logic [3:0] i, input l2cb_attr_t v);
        @(posedge I_CLK);
        I_ATTR_WE <= 1'h1;
        I_ATTR_IDX <= i;
        I_ATTR <= v;
        @(posedge I_CLK);
        I_ATTR_WE <= 1'h0;
    endtask : attr
    // Error pulses as corr, uncorr, backend, with optional clear of all
    task err(input logic [2:0] e, input logic [31:0] a, input logic c);
        @(posedge I_CLK);
        {I_ERR_CORR, I_ERR_UNCORR_RD, I_ERR_BACKEND} <= e;
        I_ERR_ADDR <= a;
        I_ERR_CLEAR <= c;
        I_PEND_CLEAR <= {4{c}};
        @(posedge I_CLK);
        {I_ERR_CORR, I_ERR_UNCORR_RD, I_ERR_BACKEND} <= 3'h0;
        I_ERR_CLEAR <= 1'h0;
        I_PEND_CLEAR <= 4'h0;
        #1;
    endtask : err
    // Watchdog far beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {I_CTRL_WE, I_FLUSH_DISABLE, I_ATTR_WE, I_ACC_VALID, I_ACC_WRITE} = '0;
        {I_ERR_CORR, I_ERR_UNCORR_RD, I_ERR_BACKEND, I_ERR_CLEAR} = '0;
        {I_ATTR_IDX, I_ACC_HPROT, I_ACC_MASTER, I_PEND_CLEAR, I_IRQ_MASK} = '0;
        I_ACC_ADDR = '0;
        I_ERR_ADDR = 32'h2000_0000; // Address reported by the write-protect event
        I_CTRL = '0;
        I_ATTR = '0;
        I_CE = 1'h1;
        I_RESET = 1'h1;
        repeat (8) @(posedge I_CLK);
        I_RESET <= 1'h0;
        @(posedge I_CLK);
        #1;
        chk("ctrl", O_CTRL, '0);
        dc(32'h1000_0000, 4'h0, 1'h0, 5'h04);
        setc(1'h1, L2CB_REPL_LRU, 1'h0, 1'h0, 2'h0);
        dc(32'h1000_0300, 4'h0, 1'h0, 5'h16);
        chk("victim", O_VICTIM, 2'h3);
        dc(32'h1015_3C50, 4'h0, 1'h0, 5'h18);
        chk("tag", O_TAG_ENTRY, 32'h1015_03D5);
        chk("half", O_HALF_SEL, 1'h1);
        dc(32'h1015_3C50, 4'h0, 1'h1, 5'h18);
        dc(32'h1000_0000, 4'h0, 1'h1, 5'h12);
        setc(1'h1, L2CB_REPL_LRU, 1'h1, 1'h0, 2'h0);
        dc(32'h1000_0040, 4'h0, 1'h0, 5'h08);
        dc(32'h1000_0040, 4'h0, 1'h1, 5'h0C);
        dc(32'h1000_0040, 4'h4, 1'h1, 5'h08);
        dc(32'h1000_0000, 4'hC, 1'h0, 5'h16);
        setc(1'h1, L2CB_REPL_LRU, 1'h1, 1'h1, 2'h0);
        dc(32'h1000_0040, 4'h0, 1'h0, 5'h04);
        dc(32'h1000_0040, 4'h4, 1'h0, 5'h08);
        for (int i = 0; i < 7; i++) begin
            acc(wa[i], 4'h0, 1'h0, 4'h0);
            chk("window", O_DEC.win, ww[i]);
        end
        setc(1'h1, L2CB_REPL_IDX_FIXED, 1'h0, 1'h0, 2'h2);
        for (int m = 0; m < 4; m++) begin
            acc(32'h1000_0000, 4'h0, 1'h0, m[3:0]);
            chk("victim", O_VICTIM, m[1:0]);
        end
        acc(32'h1000_0000, 4'h0, 1'h0, 4'h9);
        chk("victim", O_VICTIM, 2'h2);
        setc(1'h1, L2CB_REPL_IDX_MOD, 1'h0, 1'h0, 2'h2);
        acc(32'h1000_0000, 4'h0, 1'h0, 4'hF);
        chk("victim", O_VICTIM, 2'h3);
        setc(1'h1, L2CB_REPL_RANDOM, 1'h0, 1'h0, 2'h0);
        acc(32'h1000_0000, 4'h0, 1'h0, 4'h0);
        chk("valid", O_DEC_VALID, 1'h1);
        // Disable and flush first: entries and write policy change only then
        @(posedge I_CLK);
        I_FLUSH_DISABLE <= 1'h1;
        @(posedge I_CLK);
        I_FLUSH_DISABLE <= 1'h0;
        // Entry 15 write-protects one block, entry 0 uncaches a masked range
        attr(4'hF, '{14'h0800, 14'h3FFF, 2'h3, 2'h3});
        attr(4'h0, '{14'h0C00, 14'h3FF0, 2'h0, 2'h2});
        // Re-enable as write-through, LRU victims
        @(posedge I_CLK);
        I_CTRL <= '{1'h1, L2CB_REPL_LRU, 1'h1, 1'h0, 1'h0, 2'h0, 1'h1};
        I_CTRL_WE <= 1'h1;
        @(posedge I_CLK);
        I_CTRL_WE <= 1'h0;
        dc(32'h1015_3C50, 4'h0, 1'h1, 5'h1C);
        dc(32'h2000_0000, 4'h0, 1'h1, 5'h11);
        dc(32'h2000_0000, 4'h0, 1'h0, 5'h16);
        chk("pending", O_PENDING, 4'h4);
        chk("status", O_ERR_STATUS, {1'h1, L2CB_ERR_WPROT, 32'h2000_0000});
        dc(32'h303C_0000, 4'h0, 1'h0, 5'h04);
        dc(32'h3040_0000, 4'h0, 1'h0, 5'h16);
        @(posedge I_CLK);
        I_FLUSH_DISABLE <= 1'h1;
        @(posedge I_CLK);
        I_FLUSH_DISABLE <= 1'h0;
        dc(32'h2000_0000, 4'h0, 1'h1, 5'h01);
        repeat (2) @(posedge I_CLK);
        err(3'h0, 32'h0000_0000, 1'h1);
        err(3'h1, 32'h0000_1230, 1'h0);
        chk("pending", O_PENDING, 4'h8);
        chk("status", O_ERR_STATUS, {1'h1, L2CB_ERR_BACKEND, 32'h0000_1230});
        chk("irq", O_IRQ, 1'h1);
        @(posedge I_CLK);
        I_IRQ_MASK <= 4'hF;
        err(3'h4, 32'h0000_2340, 1'h0);
        chk("pending", O_PENDING, 4'h9);
        chk("irq", O_IRQ, 1'h0);
        chk("status", O_ERR_STATUS, {1'h1, L2CB_ERR_BACKEND, 32'h0000_1230});
        err(3'h2, 32'h1000_4560, 1'h0);
        chk("status", O_ERR_STATUS, {1'h1, L2CB_ERR_UNCORR, 32'h1000_4560});
        acc(32'h1000_4560, 4'h0, 1'h0, 4'h0);
        chk("err_resp", O_DEC.err_resp, 1'h1);
        acc(32'h1000_4580, 4'h0, 1'h0, 4'h0);
        chk("err_resp", O_DEC.err_resp, 1'h0);
        // Enable low must freeze the control register against a write
        @(posedge I_CLK);
        I_CE <= 1'h0;
        I_CTRL_WE <= 1'h1;
        @(posedge I_CLK);
        I_CE <= 1'h1;
        I_CTRL_WE <= 1'h0;
        #1;
        chk("frozen", O_CTRL.enable, 1'h0);
        end_sim();
    end
endmodule : tb_top
